// file: vdc_pkg.sv
/*
  vdc_pkg: constants for the video dram host controller.
  assumes a 125 mhz pclk; all timing counts derive from it.
*/
package vdc_pkg;
  // ==========================================================
  // clock and timing
  localparam int CLK_PERIOD_NS   = 8;
  localparam int INIT_PAUSE_US   = 200;
  localparam int INIT_PAUSE_CYC  = (INIT_PAUSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_CYCLES     = 8;
  localparam int RSD_FAST_NS     = 80;
  localparam int RSD_SLOW_NS     = 100;
  localparam int RSD_CYC         = (RSD_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TSL_NS          = 5;
  localparam int TSL_CYC         = (TSL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PHASE_NS        = 40;
  localparam int PHASE_CYC       = (PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SC_HALF_NS      = 16;
  localparam int SC_HALF_CYC     = (SC_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ==========================================================
  // widths
  localparam int ADDR_PINS       = 9;
  localparam int DATA_W          = 4;
  // ==========================================================
  // register offsets (apb, byte addresses)
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RDATA  = 8'h10;
  // ctrl fields: [2:0] command, [3] go, [7:4] mask, [8] serial enable
  localparam int CTRL_GO_BIT     = 3;
  localparam int CTRL_SE_BIT     = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // ==========================================================
  // commands
  typedef enum logic [2:0] {
    VDC_CMD_READ   = 3'h0,
    VDC_CMD_WRITE  = 3'h1,
    VDC_CMD_MWRITE = 3'h2,
    VDC_CMD_RDXFER = 3'h3,
    VDC_CMD_WRXFER = 3'h4,
    VDC_CMD_REFR   = 3'h5,
    VDC_CMD_SCLK   = 3'h6,
    VDC_CMD_RMW    = 3'h7
  } vdc_cmd_t;
endpackage : vdc_pkg

// file: vdc_buf2.sv
/*
  vdc_buf2: two-entry valid/ready buffer.
  assumes a single clock; both sides on pclk.
*/
`timescale 1ns/1ns
`default_nettype none
module vdc_buf2 #(
  parameter int W = 4
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic [W-1:0] mem_ff [2];
  logic         wp_ff;
  logic         rp_ff;
  logic [1:0]   cnt_ff;
  logic         push;
  logic         pop;

  assign in_ready  = (cnt_ff != 2'h2);
  assign out_valid = (cnt_ff != 2'h0);
  assign out_data  = mem_ff[rp_ff];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_ff  <= 1'b0;
      rp_ff  <= 1'b0;
      cnt_ff <= 2'h0;
    end else begin
      if (push) wp_ff <= ~wp_ff;
      if (pop) rp_ff <= ~rp_ff;
      cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge pclk) begin
    if (push) mem_ff[wp_ff] <= in_data;
  end

  AST_NO_OVERFLOW: assert property (@(posedge pclk) disable iff (!presetn)
    cnt_ff <= 2'h2) else $error("buffer count above two");
endmodule : vdc_buf2
`default_nettype wire

// file: vdc_host.sv
/*
  vdc_host: apb-controlled host that sequences strobes of a dual-port video dram.
  assumes the dram sits on the pin ports; software orders cycles over apb.
*/
`timescale 1ns/1ns
`default_nettype none
module vdc_host (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             row_strobe_n,
  output logic             col_strobe_n,
  output logic             transfer_or_output_enable_n,
  output logic             write_mask_or_write_enable_n,
  output logic             serial_enable_n,
  output logic             serial_clock,
  output logic [8:0]       multiplexed_address_pins,
  input  wire logic [3:0]  mask_and_data_pins_in,
  output logic [3:0]       mask_and_data_pins_out,
  output logic             mask_and_data_pins_oe
);
  // ==========================================================
  // state
  typedef enum logic [3:0] {
    ST_PAUSE, ST_INIT_RAS, ST_INIT_SC, ST_IDLE, ST_ROW, ST_COL, ST_WE, ST_SC, ST_END, ST_PRE
  } vdc_state_t;
  vdc_state_t  state_ff;
  logic [31:0] ctrl_ff;
  logic [17:0] addr_ff;
  logic [3:0]  wdata_ff;
  logic [15:0] cnt_ff;
  logic [4:0]  rep_ff;
  logic        busy_ff;
  logic        sio_out_ff;
  logic [8:0]  ptr_ff;
  logic [3:0]  din_s1_ff;
  logic [3:0]  din_s2_ff;
  logic        cap_valid;
  logic        rd_valid;
  logic        rd_pop;
  logic [3:0]  rd_data;
  logic        cnt_done;
  logic        col_first;
  vdc_pkg::vdc_cmd_t cmd;
  logic        wr_en;
  logic        rd_en;

  assign cmd      = vdc_pkg::vdc_cmd_t'(ctrl_ff[2:0]);
  assign cnt_done = (cnt_ff == 16'h0000);
  // first column-phase cycle: row half already latched by the dram
  assign col_first = (state_ff == ST_COL) &&
                     (cnt_ff == ((cmd == vdc_pkg::VDC_CMD_RDXFER) ?
                                 16'(vdc_pkg::RSD_CYC) : 16'(vdc_pkg::PHASE_CYC)));
  // ==========================================================
  // apb slave, zero wait states
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  assign rd_pop  = rd_en && (paddr == vdc_pkg::REG_RDATA);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff  <= vdc_pkg::CTRL_RST;
      addr_ff  <= 18'h00000;
      wdata_ff <= 4'h0;
    end else begin
      if (wr_en && paddr == vdc_pkg::REG_CTRL && !busy_ff) ctrl_ff <= pwdata;
      else if (state_ff == ST_ROW || state_ff == ST_SC) ctrl_ff[vdc_pkg::CTRL_GO_BIT] <= 1'b0;
      if (wr_en && paddr == vdc_pkg::REG_ADDR) addr_ff <= pwdata[17:0];
      if (wr_en && paddr == vdc_pkg::REG_WDATA) wdata_ff <= pwdata[3:0];
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    unique case (paddr)
      vdc_pkg::REG_CTRL:   prdata = ctrl_ff;
      vdc_pkg::REG_ADDR:   prdata = {14'h0000, addr_ff};
      vdc_pkg::REG_WDATA:  prdata = {28'h0000000, wdata_ff};
      vdc_pkg::REG_STATUS: prdata = {20'h00000, ptr_ff, sio_out_ff, rd_valid, busy_ff};
      vdc_pkg::REG_RDATA:  prdata = {27'h0000000, rd_valid, rd_data};
      default:             prdata = 32'h0000_0000;
    endcase
  end
  // ==========================================================
  // pin input synchroniser, read data buffered for the apb side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      din_s1_ff <= 4'h0;
      din_s2_ff <= 4'h0;
    end else begin
      din_s1_ff <= mask_and_data_pins_in;
      din_s2_ff <= din_s1_ff;
    end
  end
  // capture late in the column phase, after access time has passed
  assign cap_valid = (state_ff == ST_COL) && cnt_done &&
                     (cmd == vdc_pkg::VDC_CMD_READ || cmd == vdc_pkg::VDC_CMD_RMW);

  vdc_buf2 #(.W(4)) u_rdbuf (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (cap_valid),
    .in_ready  (),
    .in_data   (din_s2_ff),
    .out_valid (rd_valid),
    .out_ready (rd_pop),
    .out_data  (rd_data)
  );
  // ==========================================================
  // cycle sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_PAUSE;
      cnt_ff   <= 16'(vdc_pkg::INIT_PAUSE_CYC);
      rep_ff   <= 5'h00;
      busy_ff  <= 1'b1;
    end else begin
      if (!cnt_done) cnt_ff <= cnt_ff - 16'h0001;
      unique case (state_ff)
        ST_PAUSE: if (cnt_done) begin
          state_ff <= ST_INIT_RAS;
          cnt_ff   <= 16'(vdc_pkg::PHASE_CYC);
          rep_ff   <= 5'(vdc_pkg::INIT_CYCLES);
        end
        ST_INIT_RAS: if (cnt_done) begin
          cnt_ff <= 16'(vdc_pkg::PHASE_CYC);
          if (!row_strobe_n && rep_ff == 5'h01) begin
            state_ff <= ST_INIT_SC;
            // two toggles per serial clock; five bits so sixteen fits
            rep_ff   <= 5'(2 * vdc_pkg::INIT_CYCLES);
          end else if (!row_strobe_n) rep_ff <= rep_ff - 5'h01;
        end
        ST_INIT_SC: if (cnt_done) begin
          cnt_ff <= 16'(vdc_pkg::SC_HALF_CYC);
          rep_ff <= rep_ff - 5'h01;
          if (rep_ff == 5'h01) begin
            state_ff <= ST_IDLE;
            busy_ff  <= 1'b0;
          end
        end
        ST_IDLE: if (ctrl_ff[vdc_pkg::CTRL_GO_BIT] && rd_valid == 1'b0) begin
          busy_ff  <= 1'b1;
          state_ff <= (cmd == vdc_pkg::VDC_CMD_SCLK) ? ST_SC : ST_ROW;
          cnt_ff   <= 16'(vdc_pkg::PHASE_CYC);
          rep_ff   <= 5'h01;
        end
        ST_ROW: if (cnt_done) begin
          state_ff <= (cmd == vdc_pkg::VDC_CMD_REFR) ? ST_END : ST_COL;
          cnt_ff   <= (cmd == vdc_pkg::VDC_CMD_RDXFER) ?
                      16'(vdc_pkg::RSD_CYC) : 16'(vdc_pkg::PHASE_CYC);
        end
        ST_COL: if (cnt_done) begin
          state_ff <= (cmd == vdc_pkg::VDC_CMD_RMW) ? ST_WE : ST_END;
          cnt_ff   <= 16'(vdc_pkg::PHASE_CYC);
        end
        ST_WE: if (cnt_done) begin
          state_ff <= ST_END;
          cnt_ff   <= 16'(vdc_pkg::PHASE_CYC);
        end
        ST_SC: if (cnt_done) begin
          cnt_ff <= 16'(vdc_pkg::SC_HALF_CYC);
          if (serial_clock) begin
            state_ff <= ST_PRE;
            cnt_ff   <= 16'(vdc_pkg::TSL_CYC);
          end
        end
        ST_END: if (cnt_done) begin
          state_ff <= ST_PRE;
          cnt_ff   <= 16'(vdc_pkg::PHASE_CYC);
        end
        ST_PRE: if (cnt_done) begin
          state_ff <= ST_IDLE;
          busy_ff  <= 1'b0;
        end
      endcase
    end
  end
  // ==========================================================
  // pin drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      row_strobe_n                 <= 1'b1;
      col_strobe_n                 <= 1'b1;
      transfer_or_output_enable_n  <= 1'b1;
      write_mask_or_write_enable_n <= 1'b1;
      serial_enable_n              <= 1'b1;
      serial_clock                 <= 1'b0;
      multiplexed_address_pins     <= 9'h000;
      mask_and_data_pins_out       <= 4'h0;
      mask_and_data_pins_oe        <= 1'b0;
    end else begin
      serial_enable_n <= ~ctrl_ff[vdc_pkg::CTRL_SE_BIT];
      unique case (state_ff)
        ST_INIT_RAS: if (cnt_done) begin
          row_strobe_n                <= ~row_strobe_n;
          transfer_or_output_enable_n <= 1'b1;
        end
        ST_INIT_SC: if (cnt_done) serial_clock <= ~serial_clock;
        ST_IDLE: if (ctrl_ff[vdc_pkg::CTRL_GO_BIT] && rd_valid == 1'b0) begin
          multiplexed_address_pins <= addr_ff[17:9];
          col_strobe_n <= (cmd != vdc_pkg::VDC_CMD_REFR);
          transfer_or_output_enable_n <= !(cmd == vdc_pkg::VDC_CMD_RDXFER ||
                                           cmd == vdc_pkg::VDC_CMD_WRXFER);
          write_mask_or_write_enable_n <= !(cmd == vdc_pkg::VDC_CMD_MWRITE ||
                                            cmd == vdc_pkg::VDC_CMD_WRXFER);
          mask_and_data_pins_out <= ctrl_ff[7:4];
          mask_and_data_pins_oe  <= (cmd == vdc_pkg::VDC_CMD_MWRITE);
        end
        // only the strobe moves here: other pins would race the latch
        ST_ROW: if (cnt_done) row_strobe_n <= 1'b0;
        ST_COL: if (cnt_done) begin
          col_strobe_n <= (cmd == vdc_pkg::VDC_CMD_RMW) ? 1'b0 : 1'b1;
          if (cmd == vdc_pkg::VDC_CMD_RMW) begin
            // data settles two cycles before the late write enable
            transfer_or_output_enable_n <= 1'b1;
            mask_and_data_pins_out      <= wdata_ff;
            mask_and_data_pins_oe       <= 1'b1;
          end
        end else if (col_first) begin
          multiplexed_address_pins <= addr_ff[8:0];
          // early write: enable low one cycle ahead of column strobe
          write_mask_or_write_enable_n <= !(cmd == vdc_pkg::VDC_CMD_WRITE ||
                                            cmd == vdc_pkg::VDC_CMD_MWRITE ||
                                            cmd == vdc_pkg::VDC_CMD_WRXFER);
          mask_and_data_pins_out <= wdata_ff;
          mask_and_data_pins_oe  <= (cmd == vdc_pkg::VDC_CMD_WRITE ||
                                     cmd == vdc_pkg::VDC_CMD_MWRITE);
          transfer_or_output_enable_n <= !(cmd == vdc_pkg::VDC_CMD_READ ||
                                           cmd == vdc_pkg::VDC_CMD_RMW ||
                                           cmd == vdc_pkg::VDC_CMD_RDXFER ||
                                           cmd == vdc_pkg::VDC_CMD_WRXFER);
        end else begin
          col_strobe_n <= 1'b0;
        end
        ST_WE: if (cnt_ff == 16'(vdc_pkg::PHASE_CYC - 1)) begin
          write_mask_or_write_enable_n <= 1'b0;
        end
        ST_SC: if (cnt_done) serial_clock <= ~serial_clock;
        ST_END: if (cnt_done) begin
          row_strobe_n                 <= 1'b1;
          col_strobe_n                 <= 1'b1;
          transfer_or_output_enable_n  <= 1'b1;
          write_mask_or_write_enable_n <= 1'b1;
          mask_and_data_pins_oe        <= 1'b0;
        end
        default: ;
      endcase
    end
  end
  // ==========================================================
  // serial pointer and direction shadows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_ff     <= 9'h000;
      sio_out_ff <= 1'b1;
    end else begin
      if (state_ff == ST_SC && cnt_done && !serial_clock)
        ptr_ff <= ptr_ff + 9'h001;
      if (state_ff == ST_ROW && cnt_done) begin
        if (cmd == vdc_pkg::VDC_CMD_RDXFER) begin
          sio_out_ff <= 1'b1;
          ptr_ff     <= addr_ff[8:0];
        end else if (cmd == vdc_pkg::VDC_CMD_WRXFER) begin
          sio_out_ff <= 1'b0;
          ptr_ff     <= addr_ff[8:0];
        end
      end
    end
  end
  // ==========================================================
  // checks
  AST_STANDBY: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == ST_IDLE) |-> row_strobe_n) else $error("row strobe low in idle");
  AST_XFER_DT: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == ST_ROW && cnt_done && cmd == vdc_pkg::VDC_CMD_RDXFER)
    |=> !transfer_or_output_enable_n && !row_strobe_n) else $error("transfer pin wrong");
  AST_RDXFER_DIR: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(row_strobe_n) && !transfer_or_output_enable_n && col_strobe_n
    |-> (write_mask_or_write_enable_n == (cmd == vdc_pkg::VDC_CMD_RDXFER)))
    else $error("transfer direction wrong");
  AST_MASK_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(row_strobe_n) && cmd == vdc_pkg::VDC_CMD_MWRITE
    |-> !write_mask_or_write_enable_n) else $error("mask not enabled");
  AST_UNMASKED: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(row_strobe_n) && cmd == vdc_pkg::VDC_CMD_WRITE
    |-> $past(write_mask_or_write_enable_n)) else $error("plain write masked");
  AST_EARLY_WE: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(col_strobe_n) && cmd == vdc_pkg::VDC_CMD_WRITE
    |-> !write_mask_or_write_enable_n) else $error("write enable late");
  // cycles since a read transfer's row strobe fell, saturating
  logic [4:0]  rsd_gap_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsd_gap_ff <= 5'h1f;
    end else if (state_ff == ST_ROW && cnt_done && cmd == vdc_pkg::VDC_CMD_RDXFER) begin
      rsd_gap_ff <= 5'h00;
    end else if (rsd_gap_ff != 5'h1f) begin
      rsd_gap_ff <= rsd_gap_ff + 5'h01;
    end
  end
  AST_RSD: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(serial_clock) |-> rsd_gap_ff >= 5'(vdc_pkg::RSD_CYC))
    else $error("serial clock too soon");
  AST_PTR_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
    (ptr_ff == 9'h1ff && state_ff == ST_SC && cnt_done && !serial_clock)
    |=> ptr_ff == 9'h000) else $error("pointer did not wrap");
  sequence seq_row_half;
    multiplexed_address_pins == addr_ff[17:9];
  endsequence
  sequence seq_col_half;
    multiplexed_address_pins == addr_ff[8:0];
  endsequence
  AST_ADDR_MUX: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(row_strobe_n) && state_ff == ST_COL |-> seq_row_half ##1 seq_col_half)
    else $error("address mux");
endmodule : vdc_host
`default_nettype wire

// file: vdc_dram_model.sv
/*
  vdc_dram_model: behavioural dual-port video dram for the host bench.
  assumes pin-level strobes from the host; sparse memory, no timing beyond a few checks.
*/
`timescale 1ns/1ns
`default_nettype none
module vdc_dram_model (
  input  wire logic       row_strobe_n,
  input  wire logic       col_strobe_n,
  input  wire logic       transfer_or_output_enable_n,
  input  wire logic       write_mask_or_write_enable_n,
  input  wire logic       serial_enable_n,
  input  wire logic       serial_clock,
  input  wire logic [8:0] multiplexed_address_pins,
  input  wire logic [3:0] bus_level,
  output logic [3:0]      dram_data,
  output logic            dram_oe,
  output logic [8:0]      ptr,
  output logic            sio_out,
  output int              ras_cnt,
  output int              sc_cnt,
  output int              refr_cnt,
  output int              viol,
  output time             first_ras_t
);
  // =========
  // state
  logic [3:0]  mem [logic [17:0]];
  logic [8:0]  row;
  logic [17:0] a;
  logic [3:0]  mask;
  logic [3:0]  rdv;
  logic        ram_cyc, xfer, xfer_rd, refr, rd_ok, sc_armed, flt;
  time         ras_t;
  time         sc_t;
  initial begin
    {ras_cnt, sc_cnt, refr_cnt, viol} = '0;
    {ram_cyc, xfer, xfer_rd, refr, rd_ok, sc_armed, flt} = '0;
    ptr = 9'h000;
    sio_out = 1'b1;
    first_ras_t = 0;
    ras_t = 0;
    sc_t = 0;
  end
  // =========
  // cycle decode
  always @(negedge row_strobe_n) begin
    row = multiplexed_address_pins;
    ras_cnt++;
    if (ras_cnt == 1) first_ras_t = $time;
    refr = !col_strobe_n;
    if (refr) refr_cnt++;
    ram_cyc = !refr && transfer_or_output_enable_n;
    xfer = !refr && !transfer_or_output_enable_n;
    mask = write_mask_or_write_enable_n ? 4'hf : bus_level;
    xfer_rd = write_mask_or_write_enable_n;
    ras_t = $time;
    rd_ok = 1'b0;
  end
  task automatic wr();
    logic [3:0] old;
    old = mem.exists(a) ? mem[a] : 4'h0;
    mem[a] = (old & ~mask) | (bus_level & mask);
  endtask : wr
  always @(negedge col_strobe_n) if (!row_strobe_n && !refr) begin
    a = {row, multiplexed_address_pins};
    if (xfer) begin
      ptr = multiplexed_address_pins;
      sio_out = xfer_rd;
      sc_armed = xfer_rd;
    end else if (ram_cyc && !write_mask_or_write_enable_n) begin
      wr();
    end else if (ram_cyc) begin
      rdv = mem.exists(a) ? mem[a] : 4'h0;
      rd_ok = 1'b1;
    end
  end
  // late write enable turns a read into read-modify-write
  always @(negedge write_mask_or_write_enable_n)
    if (!row_strobe_n && !col_strobe_n && ram_cyc && rd_ok) begin
      rd_ok = 1'b0;
      wr();
    end
  // released outputs wiggle so a stale value is never mistaken for data
  always @(row_strobe_n or col_strobe_n) flt = ~flt;
  always @* begin
    dram_oe = ram_cyc && rd_ok && !row_strobe_n && !col_strobe_n
              && !transfer_or_output_enable_n;
    dram_data = dram_oe ? rdv : {4{flt}};
  end
  // =========
  // serial pointer
  always @(posedge serial_clock) begin
    sc_cnt++;
    sc_t = $time;
    if (sc_armed && ($time - ras_t) < vdc_pkg::RSD_SLOW_NS) viol++;
    if (!row_strobe_n && xfer) viol++;
    sc_armed = 1'b0;
    ptr = ptr + 9'h001;
  end
  // transfer pin rising ends a transfer; last serial clock must lead it
  always @(posedge transfer_or_output_enable_n)
    if (xfer && ($time - sc_t) < vdc_pkg::TSL_NS) viol++;
endmodule : vdc_dram_model
`default_nettype wire

// file: test_vdc_host.sv
/*
  test_vdc_host: self-checking bench for the video dram host.
  assumes vdc_pkg and the dram model; apb master with zero-wait slave tolerated.
*/
`timescale 1ns/1ns
`default_nettype none
module test_vdc_host;
  logic        pclk = 1'b0, presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr;
  logic        row_strobe_n, col_strobe_n, transfer_or_output_enable_n;
  logic        write_mask_or_write_enable_n, serial_enable_n, serial_clock;
  logic [8:0]  multiplexed_address_pins, ptr;
  logic [3:0]  mask_and_data_pins_in, mask_and_data_pins_out, dram_data;
  logic        mask_and_data_pins_oe, dram_oe, sio_out;
  int          ras_cnt, sc_cnt, refr_cnt, viol, bad_count, comparisons;
  time         first_ras_t, t_rel;
  // host wins on the shared data wire
  assign mask_and_data_pins_in = mask_and_data_pins_oe ? mask_and_data_pins_out : dram_data;
  always #4 pclk = ~pclk;
  vdc_host u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .row_strobe_n, .col_strobe_n, .transfer_or_output_enable_n,
    .write_mask_or_write_enable_n, .serial_enable_n, .serial_clock,
    .multiplexed_address_pins, .mask_and_data_pins_in, .mask_and_data_pins_out,
    .mask_and_data_pins_oe);
  vdc_dram_model u_dram (.row_strobe_n, .col_strobe_n, .transfer_or_output_enable_n,
    .write_mask_or_write_enable_n, .serial_enable_n, .serial_clock,
    .multiplexed_address_pins, .bus_level(mask_and_data_pins_in), .dram_data, .dram_oe,
    .ptr, .sio_out, .ras_cnt, .sc_cnt, .refr_cnt, .viol, .first_ras_t);
  // =========
  // helpers
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // ends once pready is seen high; only the watchdog ends it otherwise
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    check(pslverr, 1'b0, "slave error");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, vdc_pkg::REG_STATUS, 32'h0, rd);
      n++;
    end while (rd[0] !== 1'b0 && n < 10000);
    check(rd[0], 1'b0, "busy stuck");
  endtask : wait_idle
  task automatic op(input vdc_pkg::vdc_cmd_t c, input logic [17:0] ad, input logic [3:0] d,
                    input logic [3:0] m);
    apb(1'b1, vdc_pkg::REG_ADDR, {14'h0, ad}, rd);
    apb(1'b1, vdc_pkg::REG_WDATA, {28'h0, d}, rd);
    apb(1'b1, vdc_pkg::REG_CTRL, {23'h0, 1'b0, m, 1'b1, c}, rd);
    wait_idle();
  endtask : op
  // =========
  // scenarios
  task automatic t_init();
    // go during init must be ignored
    apb(1'b1, vdc_pkg::REG_CTRL, {28'h0, 1'b1, vdc_pkg::VDC_CMD_REFR}, rd);
    wait_idle();
    check(ras_cnt, vdc_pkg::INIT_CYCLES, "init row strobes");
    check(sc_cnt, vdc_pkg::INIT_CYCLES, "init serial clocks");
    check((first_ras_t - t_rel) >= 200000, 1'b1, "init pause");
    check(refr_cnt, 0, "go while busy");
    $display("test init done");
  endtask : t_init
  task automatic t_rw();
    op(vdc_pkg::VDC_CMD_WRITE, 18'h2a5c3, 4'h9, 4'h0);
    check(u_dram.mem[18'h2a5c3], 4'h9, "plain write");
    op(vdc_pkg::VDC_CMD_READ, 18'h2a5c3, 4'h0, 4'h0);
    apb(1'b0, vdc_pkg::REG_RDATA, 32'h0, rd);
    check(rd[4:0], 5'h19, "read data");
    apb(1'b0, vdc_pkg::REG_RDATA, 32'h0, rd);
    check(rd[4], 1'b0, "buffer drained");
    apb(1'b0, 8'h20, 32'h0, rd);
    check(rd, 32'h0, "unmapped read");
    $display("test rw done");
  endtask : t_rw
  task automatic t_mask_rmw();
    op(vdc_pkg::VDC_CMD_WRITE, 18'h0017f, 4'hf, 4'h0);
    op(vdc_pkg::VDC_CMD_MWRITE, 18'h0017f, 4'h0, 4'h5);
    check(u_dram.mem[18'h0017f], 4'ha, "masked write");
    op(vdc_pkg::VDC_CMD_RMW, 18'h0017f, 4'h3, 4'h0);
    check(u_dram.mem[18'h0017f], 4'h3, "read modify write");
    apb(1'b0, vdc_pkg::REG_RDATA, 32'h0, rd);
    check(rd[4:0], 5'h1a, "read modify write data");
    op(vdc_pkg::VDC_CMD_REFR, 18'h0, 4'h0, 4'h0);
    check(refr_cnt, 1, "refresh");
    $display("test mask done");
  endtask : t_mask_rmw
  task automatic t_xfer();
    op(vdc_pkg::VDC_CMD_RDXFER, {9'h011, 9'h1fe}, 4'h0, 4'h0);
    check(sio_out, 1'b1, "read transfer direction");
    repeat (3) op(vdc_pkg::VDC_CMD_SCLK, 18'h0, 4'h0, 4'h0);
    check(ptr, 9'h001, "pointer wrap");
    apb(1'b0, vdc_pkg::REG_STATUS, 32'h0, rd);
    check(rd[11:2], {9'h001, 1'b1}, "status pointer");
    op(vdc_pkg::VDC_CMD_WRXFER, {9'h011, 9'h005}, 4'h0, 4'h0);
    check(sio_out, 1'b0, "write transfer direction");
    apb(1'b0, vdc_pkg::REG_STATUS, 32'h0, rd);
    check(rd[2], 1'b0, "status input mode");
    apb(1'b1, vdc_pkg::REG_CTRL, 32'h0000_0100, rd);
    apb(1'b0, vdc_pkg::REG_STATUS, 32'h0, rd);
    check(serial_enable_n, 1'b0, "serial enable pin");
    check(viol, 0, "serial clock timing");
    $display("test xfer done");
  endtask : t_xfer
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done
  // =========
  // main
  initial begin
    bad_count = 0;
    comparisons = 0;
    repeat (6) @(posedge pclk);
    check({row_strobe_n, col_strobe_n, serial_clock, mask_and_data_pins_oe}, 4'hc,
          "reset levels");
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_rel = $time;
    t_init();
    t_rw();
    t_mask_rmw();
    t_xfer();
    test_done();
  end
  initial begin
    #(8 * 90000);
    bad_count++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    test_done();
  end
endmodule : test_vdc_host
`default_nettype wire
